// *** logic/wdrt_regs.vh ***
`ifndef WDRT_REGS_VH
`define WDRT_REGS_VH

// Register indices; byte address is four times the index
`define WDRT_IDX_PWRC 10'h087
`define WDRT_IDX_COUNT 10'h0ff
`define WDRT_IDX_STATUS 10'h080
`define WDRT_IDX_MASK 10'h081

// Power control fields
`define WDRT_PC_IDLE 0
`define WDRT_PC_PDOWN 1
`define WDRT_PC_UNLOCK 4
`define WDRT_PC_RESET 8'h00

// Event status fields
`define WDRT_EV_OVERFLOW 0
`define WDRT_EV_REFUSED 1
`define WDRT_EV_PD_BLOCKED 2
`define WDRT_EV_W 3

// Timing
`define WDRT_MC_DIV 12
`define WDRT_PRE_BITS 11
`define WDRT_CNT_BITS 8
`define WDRT_INT_RST_MC 1
`define WDRT_PIN_RST_MC 3

// Bus answers
`define WDRT_RESP_OKAY 2'b00
`define WDRT_RESP_SLVERR 2'b10

`endif

// *** logic/wdrt_count.v ***
`timescale 1ns/1ps
`default_nettype none
`include "wdrt_regs.vh"

module wdrt_count #(
	parameter MC_DIV = `WDRT_MC_DIV,
	parameter PRE_BITS = `WDRT_PRE_BITS,
	parameter CNT_BITS = `WDRT_CNT_BITS
) (
	input wire clk,
	input wire rst_n,
	input wire run,
	input wire load,
	input wire [CNT_BITS-1:0] load_val,
	output reg [CNT_BITS-1:0] count_q,
	output reg overflow_q
);

	localparam [31:0] MC_LAST_FULL = MC_DIV - 1;
	localparam [7:0] MC_LAST = MC_LAST_FULL[7:0];

	reg [7:0] mc_q;
	reg [PRE_BITS-1:0] pre_q;
	wire mc_tick;
	wire pre_tick;

	assign mc_tick = (mc_q == MC_LAST);
	assign pre_tick = mc_tick && (&pre_q);

	// Prescaler sees one edge per machine cycle
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mc_q <= 8'h00;
			pre_q <= {PRE_BITS{1'b0}};
			count_q <= {CNT_BITS{1'b0}};
			overflow_q <= 1'b0;
		end else begin
			overflow_q <= 1'b0;
			if (!run) begin
				// Disabled: timebase parked so no overflow can come
				mc_q <= 8'h00;
				pre_q <= {PRE_BITS{1'b0}};
			end else begin
				mc_q <= mc_tick ? 8'h00 : mc_q + 8'h01;
				if (mc_tick) begin
					pre_q <= pre_q + {{(PRE_BITS-1){1'b0}}, 1'b1};
				end
			end
			if (load) begin
				// A reload also restarts the prescaler phase
				count_q <= load_val;
				if (run) begin
					mc_q <= 8'h00;
					pre_q <= {PRE_BITS{1'b0}};
				end
			end else if (run && pre_tick) begin
				count_q <= count_q + {{(CNT_BITS-1){1'b0}}, 1'b1};
				if (&count_q) begin
					overflow_q <= 1'b1;
				end
			end
		end
	end

endmodule

`default_nettype wire

// *** logic/wdrt_top.v ***
`timescale 1ns/1ps
`default_nettype none
`include "wdrt_regs.vh"

module wdrt_top #(
	parameter MC_DIV = `WDRT_MC_DIV,
	parameter PRE_BITS = `WDRT_PRE_BITS
) (
	input wire SYS_CLK,
	input wire RESET_N,
	input wire WATCHDOG_ENABLE_N,
	input wire [11:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output reg S_AXI_AWREADY,
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output reg S_AXI_WREADY,
	output reg [1:0] S_AXI_BRESP,
	output reg S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire [11:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output reg S_AXI_ARREADY,
	output reg [31:0] S_AXI_RDATA,
	output reg [1:0] S_AXI_RRESP,
	output reg S_AXI_RVALID,
	input wire S_AXI_RREADY,
	output reg WDT_RESET,
	output reg RST_PIN_OUT,
	output reg IDLE_MODE,
	output reg POWER_DOWN,
	output reg IRQ
);

	localparam CNT_W = `WDRT_CNT_BITS;
	localparam EV_W = `WDRT_EV_W;
	localparam [31:0] INT_RST_FULL = `WDRT_INT_RST_MC * MC_DIV;
	localparam [31:0] PIN_RST_FULL = `WDRT_PIN_RST_MC * MC_DIV;
	// Pulse counters are 8 bits, so MC_DIV above 85 would not fit
	localparam [7:0] INT_RST_CYC = INT_RST_FULL[7:0];
	localparam [7:0] PIN_RST_CYC = PIN_RST_FULL[7:0];

	// Enable pin comes from outside, so it is synchronised first
	reg en_meta_q;
	reg en_n_q;
	wire wd_on;

	always @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			en_meta_q <= 1'b1;
			en_n_q <= 1'b1;
		end else begin
			en_meta_q <= WATCHDOG_ENABLE_N;
			en_n_q <= en_meta_q;
		end
	end

	// No software path reaches this term
	assign wd_on = ~en_n_q;

	// Write channel holding stages
	reg aw_hold_q;
	reg aw_hold_d;
	reg [11:0] aw_addr_q;
	reg w_hold_q;
	reg w_hold_d;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	wire aw_take;
	wire w_take;
	wire do_write;
	wire ar_take;

	assign aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
	assign w_take = S_AXI_WVALID && S_AXI_WREADY;
	assign do_write = aw_hold_q && w_hold_q && !S_AXI_BVALID;
	assign ar_take = S_AXI_ARVALID && S_AXI_ARREADY;

	always @* begin
		aw_hold_d = aw_hold_q;
		w_hold_d = w_hold_q;
		if (do_write) begin
			aw_hold_d = 1'b0;
			w_hold_d = 1'b0;
		end
		if (aw_take) begin
			aw_hold_d = 1'b1;
		end
		if (w_take) begin
			w_hold_d = 1'b1;
		end
	end

	// Decode of the held write
	wire [9:0] w_idx;
	wire w_lane;
	wire wr_pwrc;
	wire wr_count;
	wire wr_status;
	wire wr_mask;
	wire w_mapped;

	assign w_idx = aw_addr_q[11:2];
	assign w_lane = w_strb_q[0];
	assign wr_pwrc = do_write && w_lane && (w_idx == `WDRT_IDX_PWRC);
	assign wr_count = do_write && w_lane && (w_idx == `WDRT_IDX_COUNT);
	assign wr_status = do_write && w_lane && (w_idx == `WDRT_IDX_STATUS);
	assign wr_mask = do_write && w_lane && (w_idx == `WDRT_IDX_MASK);
	assign w_mapped = (w_idx == `WDRT_IDX_PWRC) || (w_idx == `WDRT_IDX_COUNT) ||
		(w_idx == `WDRT_IDX_STATUS) || (w_idx == `WDRT_IDX_MASK);

	// Register state
	reg [7:0] pwrc_q;
	reg [7:0] pwrc_d;
	reg [EV_W-1:0] status_q;
	reg [EV_W-1:0] status_d;
	reg [EV_W-1:0] mask_q;
	reg [EV_W-1:0] ev_set;
	wire unlock;
	wire load;
	wire [CNT_W-1:0] count;
	wire overflow;

	assign unlock = pwrc_q[`WDRT_PC_UNLOCK];
	// Only an unlocked write reaches the counter
	assign load = wr_count && unlock;

	wdrt_count #(
		.MC_DIV(MC_DIV),
		.PRE_BITS(PRE_BITS),
		.CNT_BITS(CNT_W)
	) u_count (
		.clk(SYS_CLK),
		.rst_n(RESET_N),
		.run(wd_on),
		.load(load),
		.load_val(w_data_q[CNT_W-1:0]),
		.count_q(count),
		.overflow_q(overflow)
	);

	always @* begin
		pwrc_d = pwrc_q;
		if (wr_pwrc) begin
			// Software sets unlock by read-modify-write of this byte
			pwrc_d = w_data_q[7:0];
		end
		if (load || overflow) begin
			pwrc_d[`WDRT_PC_UNLOCK] = 1'b0;
		end
		if (wd_on) begin
			// Power-down cannot coexist with a running watchdog
			pwrc_d[`WDRT_PC_PDOWN] = 1'b0;
		end
	end

	always @* begin
		ev_set = {EV_W{1'b0}};
		ev_set[`WDRT_EV_OVERFLOW] = overflow;
		ev_set[`WDRT_EV_REFUSED] = wr_count && !unlock;
		ev_set[`WDRT_EV_PD_BLOCKED] = wr_pwrc && wd_on && w_data_q[`WDRT_PC_PDOWN];
		status_d = status_q;
		if (wr_status) begin
			status_d = status_q & ~w_data_q[EV_W-1:0];
		end
		// A new event outranks a clear in the same cycle
		status_d = status_d | ev_set;
	end

	always @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pwrc_q <= `WDRT_PC_RESET;
			status_q <= {EV_W{1'b0}};
			mask_q <= {EV_W{1'b0}};
			IRQ <= 1'b0;
			IDLE_MODE <= 1'b0;
			POWER_DOWN <= 1'b0;
		end else begin
			pwrc_q <= pwrc_d;
			status_q <= status_d;
			if (wr_mask) begin
				mask_q <= w_data_q[EV_W-1:0];
			end
			IRQ <= |(status_d & mask_q);
			// Idle only stops the core; the watchdog keeps counting
			IDLE_MODE <= pwrc_d[`WDRT_PC_IDLE];
			POWER_DOWN <= pwrc_d[`WDRT_PC_PDOWN];
		end
	end

	// Reset pulses on overflow
	reg [7:0] int_cnt_q;
	reg [7:0] pin_cnt_q;

	always @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			int_cnt_q <= 8'h00;
			pin_cnt_q <= 8'h00;
			WDT_RESET <= 1'b0;
			RST_PIN_OUT <= 1'b0;
		end else begin
			if (overflow) begin
				int_cnt_q <= INT_RST_CYC;
				pin_cnt_q <= PIN_RST_CYC;
				WDT_RESET <= 1'b1;
				RST_PIN_OUT <= 1'b1;
			end else begin
				if (int_cnt_q != 8'h00) begin
					int_cnt_q <= int_cnt_q - 8'h01;
				end
				if (pin_cnt_q != 8'h00) begin
					pin_cnt_q <= pin_cnt_q - 8'h01;
				end
				WDT_RESET <= (int_cnt_q > 8'h01);
				// Pin pulse is timed separately so a loaded pin cannot shorten the internal one
				RST_PIN_OUT <= (pin_cnt_q > 8'h01);
			end
		end
	end

	// Write channel and response
	always @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			aw_addr_q <= 12'h000;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY <= 1'b1;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `WDRT_RESP_OKAY;
		end else begin
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			S_AXI_AWREADY <= !aw_hold_d;
			S_AXI_WREADY <= !w_hold_d;
			if (aw_take) begin
				aw_addr_q <= S_AXI_AWADDR;
			end
			if (w_take) begin
				w_data_q <= S_AXI_WDATA;
				w_strb_q <= S_AXI_WSTRB;
			end
			if (do_write) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= w_mapped ? `WDRT_RESP_OKAY : `WDRT_RESP_SLVERR;
			end else if (S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// Read channel
	wire [9:0] r_idx;
	reg [31:0] r_data;
	reg r_ok;

	assign r_idx = S_AXI_ARADDR[11:2];

	always @* begin
		r_data = 32'h0000_0000;
		r_ok = 1'b1;
		case (r_idx)
			`WDRT_IDX_PWRC: begin
				r_data[7:0] = pwrc_q;
			end
			`WDRT_IDX_COUNT: begin
				r_data[CNT_W-1:0] = count;
			end
			`WDRT_IDX_STATUS: begin
				r_data[EV_W-1:0] = status_q;
			end
			`WDRT_IDX_MASK: begin
				r_data[EV_W-1:0] = mask_q;
			end
			default: begin
				r_ok = 1'b0;
			end
		endcase
	end

	always @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= `WDRT_RESP_OKAY;
		end else begin
			if (ar_take) begin
				S_AXI_ARREADY <= 1'b0;
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= r_data;
				S_AXI_RRESP <= r_ok ? `WDRT_RESP_OKAY : `WDRT_RESP_SLVERR;
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
				S_AXI_ARREADY <= 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

// *** tb/wdrt_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module wdrt_monitor (
	input wire SYS_CLK,
	input wire RESET_N,
	input wire WATCHDOG_ENABLE_N,
	input wire S_AXI_AWVALID,
	input wire S_AXI_AWREADY,
	input wire S_AXI_WVALID,
	input wire S_AXI_WREADY,
	input wire S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire [1:0] S_AXI_BRESP,
	input wire S_AXI_ARVALID,
	input wire S_AXI_ARREADY,
	input wire S_AXI_RVALID,
	input wire WDT_RESET,
	input wire RST_PIN_OUT,
	input wire POWER_DOWN
);
	// Width counters, since a 36-cycle repetition would be too long to unroll
	logic [5:0] w_q;
	logic [5:0] p_q;
	always @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			w_q <= 6'h0;
			p_q <= 6'h0;
		end else begin
			w_q <= WDT_RESET ? w_q + 6'h1 : 6'h0;
			p_q <= RST_PIN_OUT ? p_q + 6'h1 : 6'h0;
		end
	end
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);
	sequence wr_take;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	endsequence
	sequence ovf_start;
		$rose(WDT_RESET);
	endsequence
	int_len_a: assert property (!WDT_RESET && w_q != 6'h0 |-> w_q == 6'hc)
		else $error("internal reset width wrong");
	pin_len_a: assert property (!RST_PIN_OUT && p_q != 6'h0 |-> p_q == 6'h24)
		else $error("pin pulse width wrong");
	pin_with_int_a: assert property (ovf_start |-> $rose(RST_PIN_OUT))
		else $error("pin pulse not with internal reset");
	off_no_reset_a: assert property (WATCHDOG_ENABLE_N [*6] |-> !$rose(WDT_RESET))
		else $error("reset while disabled");
	pd_blocked_a: assert property (!WATCHDOG_ENABLE_N [*6] |-> !POWER_DOWN)
		else $error("power down while enabled");
	wr_resp_a: assert property (wr_take |-> ##2 S_AXI_BVALID)
		else $error("write answer late");
	b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write answer dropped");
	rd_resp_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
		else $error("read answer late");
endmodule
bind wdrt_top wdrt_monitor mon (.*);
`default_nettype wire

// *** tb/wdrt_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "wdrt_regs.vh"
`define CK(n, e, g) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("CHECK FAILED %s exp %h got %h", n, e, g); \
	end \
end
module wdrt_tb_top;
	localparam int PB = 2;
	localparam logic [11:0] PC = {`WDRT_IDX_PWRC, 2'h0};
	localparam logic [11:0] CT = {`WDRT_IDX_COUNT, 2'h0};
	localparam logic [11:0] ST = {`WDRT_IDX_STATUS, 2'h0};
	localparam logic [11:0] MK = {`WDRT_IDX_MASK, 2'h0};
	logic SYS_CLK, RESET_N, WATCHDOG_ENABLE_N, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
	logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
	logic WDT_RESET, RST_PIN_OUT, IDLE_MODE, POWER_DOWN, IRQ;
	logic [11:0] S_AXI_AWADDR, S_AXI_ARADDR;
	logic [31:0] S_AXI_WDATA, S_AXI_RDATA, d;
	logic [3:0] S_AXI_WSTRB;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
	int error_cnt, tests_run, n;
	wdrt_top #(.PRE_BITS(PB)) uut (.*);
	always #12.5 SYS_CLK = ~SYS_CLK;
	task automatic results();
		if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
		@(posedge SYS_CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= v;
		S_AXI_AWVALID <= 1'h1;
		S_AXI_WVALID <= 1'h1;
		S_AXI_BREADY <= 1'h1;
		do begin
			@(posedge SYS_CLK);
			if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
			if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
		end while (S_AXI_BVALID !== 1'h1);
		rs = S_AXI_BRESP;
		S_AXI_BREADY <= 1'h0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge SYS_CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'h1;
		S_AXI_RREADY <= 1'h1;
		do begin
			@(posedge SYS_CLK);
			if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
		end while (S_AXI_RVALID !== 1'h1);
		v = S_AXI_RDATA;
		rs = S_AXI_RRESP;
		S_AXI_RREADY <= 1'h0;
	endtask
	task automatic wc(input logic [11:0] a, input logic [7:0] v);
		wr(a, {24'h0, v}, r);
	endtask
	task automatic rc(input logic [11:0] a, input logic [7:0] e);
		rd(a, d, r);
		`CK("rdata", {24'h0, e}, d)
	endtask
	task automatic t_lock();
		rc(CT, 8'h00);
		rc(PC, 8'h00);
		wc(CT, 8'h55);
		rc(CT, 8'h00);
		rc(ST, 8'h02);
		`CK("irq", 1'h0, IRQ)
		wc(MK, 8'h02);
		@(posedge SYS_CLK);
		`CK("irq", 1'h1, IRQ)
		wc(ST, 8'h02);
		@(posedge SYS_CLK);
		`CK("irq", 1'h0, IRQ)
		wr(12'h010, 32'h1, r);
		`CK("bresp", `WDRT_RESP_SLVERR, r)
		rd(12'h010, d, r);
		`CK("rresp", `WDRT_RESP_SLVERR, r)
	endtask
	task automatic t_reload();
		wc(PC, 8'h11);
		`CK("idle", 1'h1, IDLE_MODE)
		wc(CT, 8'hf0);
		rc(CT, 8'hf0);
		rc(PC, 8'h01);
		repeat (12 << PB) @(posedge SYS_CLK);
		rc(CT, 8'hf1);
		wc(PC, 8'h00);
	endtask
	task automatic t_ovf();
		wc(PC, 8'h10);
		wc(CT, 8'hff);
		n = 0;
		while (WDT_RESET !== 1'h1 && n < 300) begin
			@(posedge SYS_CLK);
			n++;
		end
		`CK("interval", 1'h1, n > (12 << PB) - 5 && n < (12 << PB) + 5)
		`CK("pin", 1'h1, RST_PIN_OUT)
		rc(ST, 8'h01);
	endtask
	task automatic t_pd();
		wc(PC, 8'h02);
		rc(PC, 8'h00);
		`CK("pd", 1'h0, POWER_DOWN)
		rc(ST, 8'h05);
		WATCHDOG_ENABLE_N <= 1'h1;
		repeat (4) @(posedge SYS_CLK);
		wc(PC, 8'h12);
		wc(CT, 8'hff);
		rc(PC, 8'h02);
		`CK("pd", 1'h1, POWER_DOWN)
		repeat (200) @(posedge SYS_CLK);
		`CK("rst", 1'h0, WDT_RESET)
		rc(CT, 8'hff);
		WATCHDOG_ENABLE_N <= 1'h0;
		repeat (8) @(posedge SYS_CLK);
		`CK("pd", 1'h0, POWER_DOWN)
	endtask
	task automatic t_rst();
		wc(PC, 8'h11);
		wc(CT, 8'h80);
		wc(PC, 8'h11);
		RESET_N <= 1'h0;
		repeat (3) @(posedge SYS_CLK);
		RESET_N <= 1'h1;
		`CK("idle", 1'h0, IDLE_MODE)
		rc(CT, 8'h00);
		rc(PC, 8'h00);
	endtask
	initial begin
		SYS_CLK = 1'h0;
		RESET_N = 1'h0;
		WATCHDOG_ENABLE_N = 1'h0;
		S_AXI_AWADDR = 12'h0;
		S_AXI_AWVALID = 1'h0;
		S_AXI_WDATA = 32'h0;
		S_AXI_WSTRB = 4'hf;
		S_AXI_WVALID = 1'h0;
		S_AXI_BREADY = 1'h0;
		S_AXI_ARADDR = 12'h0;
		S_AXI_ARVALID = 1'h0;
		S_AXI_RREADY = 1'h0;
		repeat (20) @(posedge SYS_CLK);
		RESET_N <= 1'h1;
		t_lock();
		t_reload();
		t_ovf();
		t_pd();
		t_rst();
		results();
	end
	// The whole sequence needs about five hundred cycles
	initial begin
		#(25 * 20000);
		error_cnt++;
		results();
	end
endmodule
`default_nettype wire
